// *** include/uft_pkg.sv ***
// Package for the flow control, threshold and turn-around register block
package uft_pkg;

  // Register byte offsets
  localparam logic [7:0] UFT_OFS_TX_LVL   = 8'h00;
  localparam logic [7:0] UFT_OFS_RX_LVL   = 8'h04;
  localparam logic [7:0] UFT_OFS_HI_THR   = 8'h08;
  localparam logic [7:0] UFT_OFS_LO_THR   = 8'h0C;
  localparam logic [7:0] UFT_OFS_PRESC    = 8'h10;
  localparam logic [7:0] UFT_OFS_TAT      = 8'h14;
  localparam logic [7:0] UFT_OFS_FSEL     = 8'h18;
  localparam logic [7:0] UFT_OFS_RES1     = 8'h1C;
  localparam logic [7:0] UFT_OFS_RES2     = 8'h20;
  localparam logic [7:0] UFT_OFS_PAU1     = 8'h24;
  localparam logic [7:0] UFT_OFS_PAU2     = 8'h28;
  localparam logic [7:0] UFT_OFS_CTRL     = 8'h2C;
  localparam logic [7:0] UFT_OFS_STATUS   = 8'h30;
  localparam logic [7:0] UFT_OFS_IRQ_ST   = 8'h34;
  localparam logic [7:0] UFT_OFS_IRQ_MASK = 8'h38;

  // Field positions
  localparam int UFT_CTL_NINE   = 0;
  localparam int UFT_CTL_DTR    = 1;
  localparam int UFT_EV_PAUSE   = 0;
  localparam int UFT_EV_RESUME  = 1;
  localparam int UFT_EV_HIGH    = 2;
  localparam int UFT_EV_TURN    = 3;
  localparam int UFT_NUM_EV     = 4;

  // Values after reset
  localparam logic [7:0] UFT_RST_LVL   = 8'h00;
  localparam logic [3:0] UFT_RST_PRESC = 4'h0;
  localparam logic [3:0] UFT_RST_FSEL  = 4'h0;
  localparam logic [7:0] UFT_RST_CHAR  = 8'h00;
  localparam logic [7:0] UFT_RST_TAT   = 8'h00;

  // Level encoding limits and prescaler step (sixteenths)
  localparam logic [7:0] UFT_LVL_MIN  = 8'h01;
  localparam logic [7:0] UFT_LVL_MAX  = 8'h80;
  localparam logic [5:0] UFT_PRE_STEP = 6'h10;

  typedef enum logic [2:0] {
    UFT_TX_IDLE   = 3'h1,
    UFT_TX_FIRST  = 3'h2,
    UFT_TX_SECOND = 3'h4
  } uft_txst_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } uft_char_t;

  typedef struct packed {
    logic [7:0]            txLvl;
    logic [7:0]            rxLvl;
    logic [7:0]            hiThr;
    logic [7:0]            loThr;
    logic [3:0]            presc;
    logic [7:0]            tat;
    logic [3:0]            fsel;
    logic [7:0]            res1;
    logic [7:0]            res2;
    logic [7:0]            pau1;
    logic [7:0]            pau2;
    logic                  nineBit;
    logic                  dtrSel;
    logic [UFT_NUM_EV-1:0] irqSt;
    logic [UFT_NUM_EV-1:0] irqMask;
  } uft_regs_t;

  typedef struct packed {
    uft_regs_t  regs;
    logic       wrPend;
    logic [7:0] wrAddr;
    logic [31:0] hrdata;
    logic       hreadyout;
    logic       hresp;
    uft_txst_t  txSt;
    uft_char_t  flowOut;
    logic       localPaused;
    logic       sendPause;
    logic       remotePaused;
    logic       seqRes;
    logic       seqPau;
    logic [7:0] tatCnt;
    logic       tatBusy;
    logic       dirLevel;
    logic       rtsPinN;
    logic       dtrPinN;
    logic [5:0] preAcc;
    logic       baudEn;
    logic       txTrig;
    logic       rxTrig;
    logic       irq;
  } uft_state_t;

endpackage

// *** src/uft_ctrl.sv ***
// Flow control, trigger levels, prescaler and RS-485 turn-around with AHB-Lite registers
// Function
// - Upper select bits choose transmitted pause/resume pair
// - Lower select bits choose receive pair matching
// - Mixed mode accepts either resume, either pause
// - All ones: send both, match two-char sequence
// - Transmit trigger level 1..128, zero means one
// - Receive trigger level 1..128, zero means one
// - High threshold starts flow control pause
// - Low threshold releases remote sender
// - Prescaler is four bits, reset zero
// - Count turn-around after last bit shifted
// - Zero count drives direction pin low
// - Turn-around counts bit periods, not clocks
// - Flow select bits reset to zero
// - Select bit picks RTS or DTR pin
`timescale 1ns/100ps
module uft_ctrl
  import uft_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [7:0]  rxFifoLevel,
  input  wire logic [7:0]  txFifoLevel,
  input  wire uft_char_t   rxIn,
  input  wire logic        txCharReady,
  input  wire logic        txActive,
  input  wire logic        txShiftDone,
  input  wire logic        bitTick,
  output uft_char_t        flowOut,
  output logic             remotePaused,
  output logic             txTrigger,
  output logic             rxTrigger,
  output logic             baudClkEn,
  output logic             rtsPinN,
  output logic             dtrPinN,
  output logic             irq
);

  uft_state_t            st_r;
  uft_state_t            st_nxt;
  logic                  addrPhase;
  logic [UFT_NUM_EV-1:0] ev;
  logic [UFT_NUM_EV-1:0] w1c;
  logic                  resHit;
  logic                  pauHit;
  logic [6:0]            preSum;
  logic [6:0]            preLim;

  // Level encoding: 0 and 1 both mean one, anything above 128 clamps
  function automatic logic [7:0] lvlDec(input logic [7:0] v);
    if (v == 8'h00) begin
      return UFT_LVL_MIN;
    end else if (v > UFT_LVL_MAX) begin
      return UFT_LVL_MAX;
    end
    return v;
  endfunction

  // Flow character for a pause or resume, first or second pair
  function automatic logic [7:0] pickChar(input uft_regs_t r, input logic pau,
                                          input logic second);
    if (pau) begin
      return second ? r.pau2 : r.pau1;
    end
    return second ? r.res2 : r.res1;
  endfunction

  // Register read mux; unmapped offsets read as zero
  function automatic logic [31:0] regRead(input uft_state_t s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      UFT_OFS_TX_LVL:   d[7:0] = s.regs.txLvl;
      UFT_OFS_RX_LVL:   d[7:0] = s.regs.rxLvl;
      UFT_OFS_HI_THR:   d[7:0] = s.regs.hiThr;
      UFT_OFS_LO_THR:   d[7:0] = s.regs.loThr;
      UFT_OFS_PRESC:    d[3:0] = s.regs.presc; // Upper bits reserved, read zero
      UFT_OFS_TAT:      d[7:0] = s.regs.tat;
      UFT_OFS_FSEL:     d[3:0] = s.regs.fsel;
      UFT_OFS_RES1:     d[7:0] = s.regs.res1;
      UFT_OFS_RES2:     d[7:0] = s.regs.res2;
      UFT_OFS_PAU1:     d[7:0] = s.regs.pau1;
      UFT_OFS_PAU2:     d[7:0] = s.regs.pau2;
      UFT_OFS_CTRL:     d[1:0] = {s.regs.dtrSel, s.regs.nineBit};
      UFT_OFS_STATUS:   d[6:0] = {s.txSt != UFT_TX_IDLE, s.remotePaused, s.localPaused,
                                  s.tatBusy, s.dirLevel, s.rxTrig, s.txTrig};
      UFT_OFS_IRQ_ST:   d[UFT_NUM_EV-1:0] = s.regs.irqSt;
      UFT_OFS_IRQ_MASK: d[UFT_NUM_EV-1:0] = s.regs.irqMask;
      default:          d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // Outputs straight from the state register
  assign hreadyout    = st_r.hreadyout;
  assign hresp        = st_r.hresp;
  assign hrdata       = st_r.hrdata;
  assign flowOut      = st_r.flowOut;
  assign remotePaused = st_r.remotePaused;
  assign txTrigger    = st_r.txTrig;
  assign rxTrigger    = st_r.rxTrig;
  assign baudClkEn    = st_r.baudEn;
  assign rtsPinN      = st_r.rtsPinN;
  assign dtrPinN      = st_r.dtrPinN;
  assign irq          = st_r.irq;

  // Only word transfers are expected, so hsize is not decoded
  assign addrPhase = hsel & htrans[1] & hready;
  assign preSum    = {1'b0, st_r.preAcc} + {1'b0, UFT_PRE_STEP};
  assign preLim    = {1'b0, UFT_PRE_STEP} + {3'h0, st_r.regs.presc};

  // Next-state logic for the whole block
  always_comb begin
    st_nxt = st_r;
    ev     = '0;
    w1c    = '0;
    resHit = 1'b0;
    pauHit = 1'b0;

    // Bus: capture reads at the address phase so hrdata stands in the data phase
    st_nxt.hreadyout = 1'b1;
    st_nxt.hresp     = 1'b0;
    st_nxt.wrPend    = addrPhase & hwrite;
    st_nxt.wrAddr    = haddr[7:0];
    st_nxt.hrdata    = (addrPhase & ~hwrite) ? regRead(st_r, haddr[7:0]) : 32'h0000_0000;
    if (st_r.wrPend) begin
      case (st_r.wrAddr)
        UFT_OFS_TX_LVL:   st_nxt.regs.txLvl = hwdata[7:0];
        UFT_OFS_RX_LVL:   st_nxt.regs.rxLvl = hwdata[7:0];
        UFT_OFS_HI_THR:   st_nxt.regs.hiThr = hwdata[7:0];
        UFT_OFS_LO_THR:   st_nxt.regs.loThr = hwdata[7:0];
        UFT_OFS_PRESC:    st_nxt.regs.presc = hwdata[3:0];
        UFT_OFS_TAT:      st_nxt.regs.tat = hwdata[7:0];
        UFT_OFS_FSEL:     st_nxt.regs.fsel = hwdata[3:0];
        UFT_OFS_RES1:     st_nxt.regs.res1 = hwdata[7:0];
        UFT_OFS_RES2:     st_nxt.regs.res2 = hwdata[7:0];
        UFT_OFS_PAU1:     st_nxt.regs.pau1 = hwdata[7:0];
        UFT_OFS_PAU2:     st_nxt.regs.pau2 = hwdata[7:0];
        UFT_OFS_CTRL:     begin
          st_nxt.regs.nineBit = hwdata[UFT_CTL_NINE];
          st_nxt.regs.dtrSel  = hwdata[UFT_CTL_DTR];
        end
        UFT_OFS_IRQ_ST:   w1c = hwdata[UFT_NUM_EV-1:0];
        UFT_OFS_IRQ_MASK: st_nxt.regs.irqMask = hwdata[UFT_NUM_EV-1:0];
        default:          ;
      endcase
    end

    // Receive matching; relies on payload never carrying flow characters
    if (rxIn.valid) begin
      case (st_r.regs.fsel[1:0])
        2'b10: begin
          resHit = rxIn.data == st_r.regs.res1;
          pauHit = rxIn.data == st_r.regs.pau1;
        end
        2'b01: begin
          resHit = rxIn.data == st_r.regs.res2;
          pauHit = rxIn.data == st_r.regs.pau2;
        end
        2'b11: begin
          if (st_r.regs.fsel[3:2] == 2'b11) begin
            // Two-character sequence: first then second of the same kind
            resHit = st_r.seqRes & (rxIn.data == st_r.regs.res2);
            pauHit = st_r.seqPau & (rxIn.data == st_r.regs.pau2);
          end else begin
            // Either character of a kind is accepted
            resHit = (rxIn.data == st_r.regs.res1) | (rxIn.data == st_r.regs.res2);
            pauHit = (rxIn.data == st_r.regs.pau1) | (rxIn.data == st_r.regs.pau2);
          end
        end
        default: ;
      endcase
      st_nxt.seqRes = rxIn.data == st_r.regs.res1;
      st_nxt.seqPau = rxIn.data == st_r.regs.pau1;
    end
    if (pauHit) begin
      st_nxt.remotePaused = 1'b1;
      ev[UFT_EV_PAUSE]    = 1'b1;
    end else if (resHit) begin
      st_nxt.remotePaused = 1'b0;
      ev[UFT_EV_RESUME]   = 1'b1;
    end
    // Receive flow control off: never hold our transmitter
    if (st_r.regs.fsel[1:0] == 2'b00) begin
      st_nxt.remotePaused = 1'b0;
      st_nxt.seqRes       = 1'b0;
      st_nxt.seqPau       = 1'b0;
    end

    // Transmit flow characters; upper select 01 sends the second pair, 10 the first, 11 first then second
    case (st_r.txSt)
      UFT_TX_IDLE: begin
        if (st_r.regs.fsel[3:2] == 2'b00) begin
          st_nxt.localPaused = 1'b0;
        end else if (!st_r.localPaused && rxFifoLevel >= lvlDec(st_r.regs.hiThr)) begin
          st_nxt.localPaused   = 1'b1;
          st_nxt.sendPause     = 1'b1;
          st_nxt.flowOut.valid = 1'b1;
          st_nxt.flowOut.data  = pickChar(st_r.regs, 1'b1, ~st_r.regs.fsel[3]);
          st_nxt.txSt          = UFT_TX_FIRST;
          ev[UFT_EV_HIGH]      = 1'b1;
        end else if (st_r.localPaused && rxFifoLevel < lvlDec(st_r.regs.loThr)) begin
          st_nxt.localPaused   = 1'b0;
          st_nxt.sendPause     = 1'b0;
          st_nxt.flowOut.valid = 1'b1;
          st_nxt.flowOut.data  = pickChar(st_r.regs, 1'b0, ~st_r.regs.fsel[3]);
          st_nxt.txSt          = UFT_TX_FIRST;
        end
      end
      UFT_TX_FIRST: begin
        if (txCharReady) begin
          if (st_r.regs.fsel[3:2] == 2'b11) begin
            st_nxt.flowOut.data = pickChar(st_r.regs, st_r.sendPause, 1'b1);
            st_nxt.txSt         = UFT_TX_SECOND;
          end else begin
            st_nxt.flowOut.valid = 1'b0;
            st_nxt.txSt          = UFT_TX_IDLE;
          end
        end
      end
      UFT_TX_SECOND: begin
        if (txCharReady) begin
          st_nxt.flowOut.valid = 1'b0;
          st_nxt.txSt          = UFT_TX_IDLE;
        end
      end
      default: begin
        st_nxt.flowOut.valid = 1'b0;
        st_nxt.txSt          = UFT_TX_IDLE;
      end
    endcase

    // Turn-around: a fresh end of frame restarts the count, so it takes priority
    if (!st_r.regs.nineBit) begin
      st_nxt.tatBusy  = 1'b0;
      st_nxt.dirLevel = 1'b0;
    end else if (txShiftDone) begin
      st_nxt.tatCnt   = st_r.regs.tat;
      st_nxt.tatBusy  = 1'b1;
      st_nxt.dirLevel = 1'b1;
    end else if (txActive) begin
      st_nxt.tatBusy  = 1'b0;
      st_nxt.dirLevel = 1'b1;
    end else if (st_r.tatBusy) begin
      if (st_r.tatCnt == 8'h00) begin
        st_nxt.tatBusy  = 1'b0;
        st_nxt.dirLevel = 1'b0;
        ev[UFT_EV_TURN] = 1'b1;
      end else if (bitTick) begin
        st_nxt.tatCnt = st_r.tatCnt - 8'h01;
      end
    end
    // Selected pin follows direction; the other stays high
    st_nxt.rtsPinN = ~st_r.regs.nineBit | st_r.regs.dtrSel | st_nxt.dirLevel;
    st_nxt.dtrPinN = ~st_r.regs.nineBit | ~st_r.regs.dtrSel | st_nxt.dirLevel;

    // Fractional prescaler: one enable every (16+p)/16 clocks on average
    if (preSum >= preLim) begin
      st_nxt.baudEn = 1'b1;
      st_nxt.preAcc = 6'(preSum - preLim);
    end else begin
      st_nxt.baudEn = 1'b0;
      st_nxt.preAcc = preSum[5:0];
    end

    // FIFO trigger comparisons
    st_nxt.txTrig = txFifoLevel <= lvlDec(st_r.regs.txLvl);
    st_nxt.rxTrig = rxFifoLevel >= lvlDec(st_r.regs.rxLvl);

    // Sticky events: a new event wins over a clear in the same cycle
    st_nxt.regs.irqSt = (st_r.regs.irqSt & ~w1c) | ev;
    st_nxt.irq        = |(st_nxt.regs.irqSt & st_nxt.regs.irqMask);

    // Synchronous reset to constants
    if (rst) begin
      st_nxt            = '0;
      st_nxt.regs.txLvl = UFT_RST_LVL;
      st_nxt.regs.rxLvl = UFT_RST_LVL;
      st_nxt.regs.hiThr = UFT_RST_LVL;
      st_nxt.regs.loThr = UFT_RST_LVL;
      st_nxt.regs.presc = UFT_RST_PRESC;
      st_nxt.regs.tat   = UFT_RST_TAT;
      st_nxt.regs.fsel  = UFT_RST_FSEL;
      st_nxt.regs.res1  = UFT_RST_CHAR;
      st_nxt.regs.res2  = UFT_RST_CHAR;
      st_nxt.regs.pau1  = UFT_RST_CHAR;
      st_nxt.regs.pau2  = UFT_RST_CHAR;
      st_nxt.txSt       = UFT_TX_IDLE;
      st_nxt.hreadyout  = 1'b1;
      st_nxt.rtsPinN    = 1'b1;
      st_nxt.dtrPinN    = 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  property p_rx_single;
    (rxIn.valid && st_r.regs.fsel[1:0] == 2'b10 && rxIn.data == st_r.regs.pau1)
      |=> remotePaused;
  endproperty
  a_rx_single: assert property (p_rx_single) else $error("pause not seen");
  property p_rx_either;
    (rxIn.valid && st_r.regs.fsel == 4'b1011 && rxIn.data == st_r.regs.pau2)
      |=> remotePaused;
  endproperty
  a_rx_either: assert property (p_rx_either) else $error("either pause missed");
  property p_rx_pair;
    (rxIn.valid && st_r.regs.fsel == 4'b1111 && !st_r.seqPau && !remotePaused)
      |=> !remotePaused;
  endproperty
  a_rx_pair: assert property (p_rx_pair) else $error("lone char paused");
  property p_tx_pause;
    (st_r.txSt == UFT_TX_IDLE && st_r.regs.fsel[3:2] == 2'b10 && !st_r.localPaused
     && rxFifoLevel >= lvlDec(st_r.regs.hiThr))
      |=> flowOut.valid && flowOut.data == st_r.regs.pau1;
  endproperty
  a_tx_pause: assert property (p_tx_pause) else $error("pause char not sent");
  property p_tx_both;
    (st_r.txSt == UFT_TX_FIRST && st_r.regs.fsel[3:2] == 2'b11 && txCharReady)
      |=> flowOut.valid && st_r.txSt == UFT_TX_SECOND;
  endproperty
  a_tx_both: assert property (p_tx_both) else $error("second char skipped");
  property p_turn_zero;
    (st_r.regs.nineBit && txShiftDone && st_r.regs.tat == 8'h00)
      ##1 (st_r.regs.nineBit && !txActive && !txShiftDone)
      |=> ((st_r.regs.dtrSel ? dtrPinN : rtsPinN) == 1'b0);
  endproperty
  a_turn_zero: assert property (p_turn_zero) else $error("pin not turned");
  property p_turn_hold;
    (st_r.tatBusy && st_r.tatCnt != 8'h00 && !bitTick && !txShiftDone && !txActive
     && st_r.regs.nineBit)
      |=> st_r.tatBusy && st_r.tatCnt == $past(st_r.tatCnt);
  endproperty
  a_turn_hold: assert property (p_turn_hold) else $error("count moved off tick");
  property p_presc_zero;
    (st_r.regs.presc == 4'h0) |=> baudClkEn;
  endproperty
  a_presc_zero: assert property (p_presc_zero) else $error("undivided clock gap");
  property p_rx_trig;
    rxTrigger == ($past(rxFifoLevel) >= lvlDec($past(st_r.regs.rxLvl)));
  endproperty
  a_rx_trig: assert property (p_rx_trig) else $error("rx trigger wrong");
  property p_tx_trig;
    !$past(rst) |-> txTrigger == ($past(txFifoLevel) <= lvlDec($past(st_r.regs.txLvl)));
  endproperty
  a_tx_trig: assert property (p_tx_trig) else $error("tx trigger wrong");

endmodule // uft_ctrl

// *** test/uft_remote_station.sv ***
// Remote station model: takes flow characters and paces bit periods
`timescale 1ns/100ps
module uft_remote_station
  import uft_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst,
  input  wire uft_char_t flowOut,
  input  wire logic      slow,
  output logic           txCharReady,
  output logic           bitTick
);
  logic [7:0] gotQ[$];
  logic [1:0] tickCnt;

  // One bit period is four clocks; stalls only while slow is asked for
  always @(posedge mclk) begin
    if (rst) begin
      txCharReady <= 1'b0;
      bitTick     <= 1'b0;
      tickCnt     <= 2'h0;
    end else begin
      tickCnt <= tickCnt + 2'h1;
      bitTick <= (tickCnt == 2'h3);
      // Ready drops after each accept so a pair arrives as two characters
      if (flowOut.valid && txCharReady) begin
        gotQ.push_back(flowOut.data);
      end
      txCharReady <= flowOut.valid && !txCharReady && (!slow || $urandom_range(3) == 0);
    end
  end
endmodule // uft_remote_station

// *** test/uft_ctrl_tb_top.sv ***
// Self-checking bench for the flow control, trigger and turn-around block
`timescale 1ns/100ps
module uft_ctrl_tb_top;
  import uft_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  rxFifoLevel = 8'h00;
  logic [7:0]  txFifoLevel = 8'h00;
  uft_char_t   rxIn = '0;
  logic        txActive = 1'b0;
  logic        txShiftDone = 1'b0;
  logic        slow = 1'b0;
  uft_char_t   flowOut;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout, hresp, txCharReady, bitTick, remotePaused;
  logic        txTrigger, rxTrigger, baudClkEn, rtsPinN, dtrPinN, irq;
  int          n_fail = 0;
  int          compares = 0;
  int          v, d, hi, lo, n, t, k, c;

  always #5 mclk = ~mclk;

  uft_ctrl u_uft_ctrl (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxFifoLevel(rxFifoLevel),
    .txFifoLevel(txFifoLevel), .rxIn(rxIn), .txCharReady(txCharReady), .txActive(txActive),
    .txShiftDone(txShiftDone), .bitTick(bitTick), .flowOut(flowOut),
    .remotePaused(remotePaused), .txTrigger(txTrigger), .rxTrigger(rxTrigger),
    .baudClkEn(baudClkEn), .rtsPinN(rtsPinN), .dtrPinN(dtrPinN), .irq(irq));

  uft_remote_station u_uft_remote_station (.mclk(mclk), .rst(rst), .flowOut(flowOut),
    .slow(slow), .txCharReady(txCharReady), .bitTick(bitTick));

  // Verdict and end of run
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int m);
    repeat (m) @(posedge mclk);
  endtask

  // Bounded wait for hready; a hang ends the run as a failure
  task automatic waitRdy();
    int w;
    w = 0;
    do begin
      @(posedge mclk);
      w++;
    end while (hreadyout !== 1'b1 && w < 50);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
  endtask

  // One single word transfer; read data taken at the data phase edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= dat;
    waitRdy();
    rd = hrdata;
    check(hresp, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    ahb(1'b1, a, dat);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  function automatic int dec(input int x);
    return (x == 0) ? 1 : x;
  endfunction

  // Waits for m flow characters, then proves no more follow
  task automatic expQ(input int m, input logic [7:0] c1, input logic [7:0] c2);
    int w;
    w = 0;
    while (u_uft_remote_station.gotQ.size() < m && w < 300) begin
      tick(1);
      w++;
    end
    tick(12);
    check(u_uft_remote_station.gotQ.size(), m);
    if (m > 0) check(u_uft_remote_station.gotQ[0], c1);
    if (m > 1) check(u_uft_remote_station.gotQ[1], c2);
    u_uft_remote_station.gotQ.delete();
  endtask

  // One received character, then the remote pause state
  task automatic rxc(input logic [3:0] e, input logic [7:0] ch, input logic x);
    wr(UFT_OFS_FSEL, {28'h0, e});
    rxIn <= {1'b1, ch};
    tick(1);
    rxIn <= {1'b0, ~ch};
    tick(2);
    check(remotePaused, x);
  endtask

  initial begin
    void'($urandom(32'hEAC3));
    tick(20);
    rst <= 1'b0;
    // Reset values, unmapped word and reserved bits
    for (int a = 0; a < 'h40; a += 4) begin
      if (a != 'h30) rdc(8'(a), 32'h0);
    end
    for (int a = 0; a < 'h2C; a += 4) begin
      v = $urandom();
      wr(8'(a), v);
      rdc(8'(a), v & ((a == 'h10 || a == 'h18) ? 32'hF : 32'hFF));
    end
    wr(UFT_OFS_FSEL, 32'h0); // All select bits cleared before any special detect use
    // Trigger levels at and around each decoded value
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 0 : (i == 1) ? 1 : (i == 2) ? 'h80 : $urandom_range(127, 2);
      d = dec(v);
      wr(UFT_OFS_TX_LVL, v);
      wr(UFT_OFS_RX_LVL, v);
      for (int l = d - 1; l <= d + 1 && l <= 128; l++) begin
        txFifoLevel <= 8'(l);
        rxFifoLevel <= 8'(l);
        tick(3);
        check(txTrigger, l <= d);
        check(rxTrigger, l >= d);
      end
    end
    // Pause and resume characters for each transmit selection
    wr(UFT_OFS_PAU1, 32'h13);
    wr(UFT_OFS_PAU2, 32'h93);
    wr(UFT_OFS_RES1, 32'h11);
    wr(UFT_OFS_RES2, 32'h91);
    for (int s = 1; s < 4; s++) begin
      hi = $urandom_range(128, 2);
      lo = $urandom_range(hi - 1, 0);
      // Empty FIFO first, so a level left from before cannot fire the new selection
      rxFifoLevel <= 8'h00;
      slow <= s[0];
      wr(UFT_OFS_HI_THR, hi);
      wr(UFT_OFS_LO_THR, lo);
      wr(UFT_OFS_FSEL, s << 2);
      rxFifoLevel <= 8'(hi - 1);
      expQ(0, 8'h00, 8'h00);
      rxFifoLevel <= 8'(hi);
      expQ(s == 3 ? 2 : 1, s[1] ? 8'h13 : 8'h93, 8'h93);
      rxFifoLevel <= 8'(dec(lo));
      expQ(0, 8'h00, 8'h00);
      rxFifoLevel <= 8'(dec(lo) - 1);
      expQ(s == 3 ? 2 : 1, s[1] ? 8'h11 : 8'h91, 8'h91);
    end
    // Receive matching; payload avoids every flow character
    rxc(4'h2, 8'h13, 1'b1);
    rxc(4'h2, 8'($urandom_range(8'h7F, 8'h20)), 1'b1);
    rxc(4'h2, 8'h11, 1'b0);
    rxc(4'h1, 8'h13, 1'b0);
    rxc(4'h1, 8'h93, 1'b1);
    rxc(4'h1, 8'h11, 1'b1);
    rxc(4'h1, 8'h91, 1'b0);
    rxc(4'hB, 8'h93, 1'b1);
    rxc(4'hB, 8'h11, 1'b0);
    rxc(4'h7, 8'h13, 1'b1);
    rxc(4'h7, 8'h91, 1'b0);
    rxc(4'hF, 8'h13, 1'b0);
    rxc(4'hF, 8'h93, 1'b1);
    rxc(4'hF, 8'h11, 1'b1);
    rxc(4'hF, 8'h91, 1'b0);
    rxc(4'h0, 8'h13, 1'b0);
    // Interrupt: raise while masked, unmask, clear by writing one
    wr(UFT_OFS_IRQ_ST, 32'hF);
    rxc(4'h2, 8'h13, 1'b1);
    check(irq, 32'h0);
    rdc(UFT_OFS_IRQ_ST, 32'h1);
    wr(UFT_OFS_IRQ_MASK, 32'h1);
    tick(2);
    check(irq, 32'h1);
    wr(UFT_OFS_IRQ_ST, 32'h1);
    tick(2);
    check(irq, 32'h0);
    wr(UFT_OFS_IRQ_MASK, 32'h0);
    // Turn-around countdown in bit periods on either direction pin
    for (int s = 0; s < 3; s++) begin
      n = (s == 0) ? 0 : $urandom_range(6, 1);
      wr(UFT_OFS_TAT, n);
      wr(UFT_OFS_CTRL, (s == 2) ? 3 : 1);
      txActive <= 1'b1;
      tick(5);
      check(s == 2 ? dtrPinN : rtsPinN, 32'h1);
      txActive <= 1'b0;
      txShiftDone <= 1'b1;
      tick(1);
      txShiftDone <= 1'b0;
      t = 0;
      k = 0;
      while ((s == 2 ? dtrPinN : rtsPinN) === 1'b1 && k < 500) begin
        tick(1);
        t += bitTick;
        k++;
      end
      if (n > 0) check(t, n);
      else check(k <= 3, 32'h1);
      check(s == 2 ? dtrPinN : rtsPinN, 32'h0);
      check(s == 2 ? rtsPinN : dtrPinN, 32'h1);
    end
    // Prescaler: enables per window of 16 * (16 + p) clocks
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 0 : (i == 1) ? 15 : $urandom_range(14, 1);
      wr(UFT_OFS_PRESC, v);
      tick(4);
      c = 0;
      repeat (16 * (16 + v)) begin
        tick(1);
        c += baudClkEn;
      end
      check(c >= 255 && c <= 257, 32'h1);
    end
    wrap_up();
  end
endmodule // uft_ctrl_tb_top
